// >>> rtl/thl_pkg.sv
// Constants, register map and mode codes of the hardware limit timer.
package thl_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] THL_ADR_COUNT = 8'h00;
    localparam logic [7:0] THL_ADR_PERIOD = 8'h04;
    localparam logic [7:0] THL_ADR_CTRL = 8'h08;
    localparam int THL_RUN_BIT = 7;
    localparam int THL_MODE_LSB = 0;
    localparam int THL_MODE_W = 5;
    localparam int THL_CNT_W = 8;
    localparam logic [7:0] THL_COUNT_RST = 8'h00;
    localparam logic [7:0] THL_PERIOD_RST = 8'hFF;
    localparam logic [1:0] THL_HOLD_TICKS = 2'h2;
    // ****************************************
    // Mode codes
    // ****************************************
    localparam logic [4:0] THL_M_FREE = 5'h00;
    localparam logic [4:0] THL_M_LIM_ANY = 5'h03;
    localparam logic [4:0] THL_M_LIM_RISE = 5'h04;
    localparam logic [4:0] THL_M_LIM_FALL = 5'h05;
    localparam logic [4:0] THL_M_LVL_LOW = 5'h06;
    localparam logic [4:0] THL_M_LVL_HIGH = 5'h07;
    localparam logic [4:0] THL_M_OS_SW = 5'h08;
    localparam logic [4:0] THL_M_OS_RISE = 5'h09;
    localparam logic [4:0] THL_M_OS_FALL = 5'h0A;
    localparam logic [4:0] THL_M_OS_ANY = 5'h0B;
    localparam logic [4:0] THL_M_OSL_RISE = 5'h0C;
    localparam logic [4:0] THL_M_OSL_FALL = 5'h0D;
    localparam logic [4:0] THL_M_LRE_LOW = 5'h0E;
    localparam logic [4:0] THL_M_LRE_HIGH = 5'h0F;
    localparam logic [4:0] THL_M_MONO_RISE = 5'h11;
    localparam logic [4:0] THL_M_MONO_FALL = 5'h12;
    localparam logic [4:0] THL_M_MONO_ANY = 5'h13;
    localparam logic [4:0] THL_M_LOS_LOW = 5'h16;
    localparam logic [4:0] THL_M_LOS_HIGH = 5'h17;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] count;
        logic [7:0] period;
        logic [4:0] mode;
        logic run;
        logic armed;
        logic ers_s1;
        logic ers_s2;
        logic ers_prev;
        logic tck_s1;
        logic tck_s2;
        logic tck_prev;
        logic pend_rise;
        logic pend_fall;
        logic lvl_h1;
        logic lvl_h2;
        logic [1:0] hold;
    } thl_state_s;
endpackage

// >>> rtl/thl_timer.sv
// Eight-bit period timer with hardware limit, one-shot and monostable modes.
`timescale 1ns/1ns
// ****************************************
// Overview of operation
// - Running count increments, wraps to zero after match.
// - Edge limit modes reset count on selected edge.
// - Level limit modes reset count at selected level.
// - Level limit modes ignore signal while stopped.
// - Level reset acts two ticks after assertion.
// - Counting resumes two ticks after level release.
// - Software one-shot clears run bit at match.
// - Software one-shot pauses and resumes with run bit.
// - One-shot match clears run, holds count zero.
// - Edge one-shot starts on edge after run set.
// - Stopping edge one-shot needs a new start edge.
// - Edge limit one-shot starts first edge, resets later.
// - After reset edge, counting resumes two ticks later.
// - Edge limit one-shot clears run at match.
// - Level reset held; start on transition to inactive.
// - After run cleared, fresh start edge required.
// - Monostable starts on edge, stops at match.
// - Monostable match stops at zero, run stays.
// - Level one-shot counts when run and not reset.
// - After run cleared, reset held until both conditions.
// ****************************************
module thl_timer
    import thl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer_clk_i,
    input wire logic ext_reset_signal_i,
    output logic [7:0] count_value_o,
    output logic run_o
);
    thl_state_s st_r;
    thl_state_s st_nxt;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic tick;
        logic rise;
        logic fall;
        logic e_rise;
        logic e_fall;
        logic e_any;
        logic match;
        logic req;
        logic lvl;
        logic [7:0] inc;
        tick = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        e_rise = 1'b0;
        e_fall = 1'b0;
        e_any = 1'b0;
        match = 1'b0;
        req = 1'b0;
        lvl = 1'b0;
        inc = 8'h00;
        st_nxt = st_r;
        // The first stage of each synchroniser feeds only the second stage.
        st_nxt.ers_s1 = ext_reset_signal_i;
        st_nxt.ers_s2 = st_r.ers_s1;
        st_nxt.ers_prev = st_r.ers_s2;
        st_nxt.tck_s1 = timer_clk_i;
        st_nxt.tck_s2 = st_r.tck_s1;
        st_nxt.tck_prev = st_r.tck_s2;
        tick = st_r.tck_s2 & ~st_r.tck_prev;
        rise = st_r.ers_s2 & ~st_r.ers_prev;
        fall = ~st_r.ers_s2 & st_r.ers_prev;
        // Edges seen while run is set are kept until the next timer tick, so a slow timer clock misses none.
        e_rise = st_r.pend_rise | rise;
        e_fall = st_r.pend_fall | fall;
        e_any = e_rise | e_fall;
        st_nxt.pend_rise = st_r.run & e_rise & ~tick;
        st_nxt.pend_fall = st_r.run & e_fall & ~tick;
        match = (st_r.count == st_r.period);
        inc = st_r.count + 8'h01;
        if (st_r.mode == THL_M_LOS_LOW || st_r.mode == THL_M_LVL_LOW)
        begin
            lvl = ~st_r.ers_s2;
        end
        else if (st_r.mode == THL_M_LRE_LOW)
        begin
            lvl = ~st_r.ers_s2;
        end
        else
        begin
            lvl = st_r.ers_s2;
        end
        if (!st_r.run)
        begin
            st_nxt.armed = 1'b0;
            st_nxt.lvl_h1 = 1'b0;
            st_nxt.lvl_h2 = 1'b0;
            st_nxt.hold = 2'h0;
        end
        else if (tick)
        begin
            case (st_r.mode)
                THL_M_FREE:
                begin
                    st_nxt.count = match ? THL_COUNT_RST : inc;
                end
                THL_M_LIM_ANY, THL_M_LIM_RISE, THL_M_LIM_FALL:
                begin
                    if (match || (st_r.mode == THL_M_LIM_ANY && e_any) || (st_r.mode == THL_M_LIM_RISE && e_rise)
                        || (st_r.mode == THL_M_LIM_FALL && e_fall))
                    begin
                        st_nxt.count = THL_COUNT_RST;
                    end
                    else
                    begin
                        st_nxt.count = inc;
                    end
                end
                THL_M_LVL_LOW, THL_M_LVL_HIGH:
                begin
                    st_nxt.lvl_h1 = lvl;
                    st_nxt.lvl_h2 = st_r.lvl_h1;
                    if (st_r.lvl_h2 || match)
                    begin
                        st_nxt.count = THL_COUNT_RST;
                    end
                    else
                    begin
                        st_nxt.count = inc;
                    end
                end
                THL_M_OS_SW:
                begin
                    if (match)
                    begin
                        st_nxt.count = THL_COUNT_RST;
                        st_nxt.run = 1'b0;
                    end
                    else
                    begin
                        st_nxt.count = inc;
                    end
                end
                THL_M_OS_RISE, THL_M_OS_FALL, THL_M_OS_ANY,
                THL_M_MONO_RISE, THL_M_MONO_FALL, THL_M_MONO_ANY:
                begin
                    req = (st_r.mode[1:0] == 2'h1) ? e_rise : ((st_r.mode[1:0] == 2'h2) ? e_fall : e_any);
                    if (!st_r.armed)
                    begin
                        st_nxt.armed = req;
                    end
                    else if (match)
                    begin
                        st_nxt.count = THL_COUNT_RST;
                        st_nxt.armed = 1'b0;
                        st_nxt.run = st_r.mode[4];
                    end
                    else
                    begin
                        st_nxt.count = inc;
                    end
                end
                THL_M_OSL_RISE, THL_M_OSL_FALL:
                begin
                    req = (st_r.mode == THL_M_OSL_RISE) ? e_rise : e_fall;
                    if (!st_r.armed)
                    begin
                        st_nxt.armed = req;
                    end
                    else if (match)
                    begin
                        st_nxt.count = THL_COUNT_RST;
                        st_nxt.armed = 1'b0;
                        st_nxt.run = 1'b0;
                        st_nxt.hold = 2'h0;
                    end
                    else if (req)
                    begin
                        st_nxt.count = THL_COUNT_RST;
                        st_nxt.hold = THL_HOLD_TICKS - 2'h1;
                    end
                    else if (st_r.hold != 2'h0)
                    begin
                        st_nxt.hold = st_r.hold - 2'h1;
                    end
                    else
                    begin
                        st_nxt.count = inc;
                    end
                end
                THL_M_LRE_LOW, THL_M_LRE_HIGH:
                begin
                    req = (st_r.mode == THL_M_LRE_LOW) ? e_rise : e_fall;
                    if (lvl)
                    begin
                        st_nxt.count = THL_COUNT_RST;
                        st_nxt.armed = 1'b0;
                    end
                    else if (!st_r.armed)
                    begin
                        st_nxt.armed = req;
                    end
                    else if (match)
                    begin
                        st_nxt.count = THL_COUNT_RST;
                        st_nxt.armed = 1'b0;
                        st_nxt.run = 1'b0;
                    end
                    else
                    begin
                        st_nxt.count = inc;
                    end
                end
                THL_M_LOS_LOW, THL_M_LOS_HIGH:
                begin
                    if (lvl)
                    begin
                        st_nxt.count = THL_COUNT_RST;
                    end
                    else if (match)
                    begin
                        st_nxt.count = THL_COUNT_RST;
                        st_nxt.run = 1'b0;
                    end
                    else
                    begin
                        st_nxt.count = inc;
                    end
                end
                default:
                begin
                    st_nxt.count = st_r.count;
                end
            endcase
        end
        // Register access; a software write to the control word overrides a hardware clear in the same cycle.
        st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
        if (wb_cyc_i && wb_stb_i && !st_r.ack)
        begin
            case (wb_adr_i)
                THL_ADR_COUNT:
                begin
                    st_nxt.rdata = {24'h000000, st_r.count};
                end
                THL_ADR_PERIOD:
                begin
                    st_nxt.rdata = {24'h000000, st_r.period};
                end
                THL_ADR_CTRL:
                begin
                    st_nxt.rdata = {24'h000000, st_r.run, 2'h0, st_r.mode};
                end
                default:
                begin
                    st_nxt.rdata = 32'h00000000;
                end
            endcase
            if (wb_we_i && wb_sel_i[0])
            begin
                case (wb_adr_i)
                    THL_ADR_COUNT:
                    begin
                        st_nxt.count = wb_dat_i[THL_CNT_W-1:0];
                    end
                    THL_ADR_PERIOD:
                    begin
                        st_nxt.period = wb_dat_i[THL_CNT_W-1:0];
                    end
                    THL_ADR_CTRL:
                    begin
                        st_nxt.run = wb_dat_i[THL_RUN_BIT];
                        st_nxt.mode = wb_dat_i[THL_MODE_LSB +: THL_MODE_W];
                    end
                    default:
                    begin
                        st_nxt.rdata = 32'h00000000;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
            st_r.period <= THL_PERIOD_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdata;
    assign count_value_o = st_r.count;
    assign run_o = st_r.run;
endmodule // thl_timer

// >>> verif/thl_src.sv
// Model of the timer clock pin and the external reset signal source.
`timescale 1ns/1ns
module thl_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic lvl_i,
    output logic timer_clk_o,
    output logic ext_reset_signal_o
);
    logic [2:0] cnt_r;
    // The pin clock stands still between requested ticks, so each tick is counted exactly once.
    always_ff @(posedge clk_i)
    begin
        ext_reset_signal_o <= lvl_i;
        if (rst_i)
            cnt_r <= 3'h0;
        else if (cnt_r != 3'h0)
            cnt_r <= cnt_r - 3'h1;
        else if (tick_i)
            cnt_r <= 3'h7;
    end
    assign timer_clk_o = (cnt_r > 3'h4);
endmodule // thl_src

// >>> verif/thl_timer_monitor.sv
// Checker of the bus handshake and the count behaviour at the timer ports.
`timescale 1ns/1ns
module thl_timer_chk
    import thl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] count_value_o,
    input wire logic run_o
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_rd_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_rd_count;
        wb_ack_o && !wb_we_i && wb_adr_i == THL_ADR_COUNT |-> wb_dat_o[7:0] == $past(count_value_o);
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("count read wrong");
    property p_step;
        $changed(count_value_o) && !wb_ack_o |-> count_value_o == $past(count_value_o) + 8'h01 || count_value_o == 8'h00;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_hw_stop; $fell(run_o) && !wb_ack_o |-> count_value_o == 8'h00; endproperty
    a_hw_stop: assert property (p_hw_stop) else $error("run cleared off zero");
    property p_sw_start; $rose(run_o) |-> wb_ack_o && wb_we_i; endproperty
    a_sw_start: assert property (p_sw_start) else $error("run set by hardware");
    property p_frozen; !$past(run_o) && !wb_ack_o |-> $stable(count_value_o); endproperty
    a_frozen: assert property (p_frozen) else $error("count moved while stopped");
    c_hw_stop: cover property ($fell(run_o) && !wb_ack_o);
    c_wrap: cover property (count_value_o == 8'h00 && $past(count_value_o) == 8'h05);
    c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // thl_timer_chk
bind thl_timer thl_timer_chk thl_timer_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .count_value_o, .run_o);

// >>> verif/testbench.sv
// Self-checking testbench of the hardware limit timer.
`timescale 1ns/1ns
module testbench
    import thl_pkg::*;
;
    typedef struct packed {logic [4:0] mode; logic lvl; logic tog; logic [3:0] n; logic [7:0] cnt; logic run;} thl_row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, tick_r = 1'b0, lvl_r = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, run_o, timer_clk, ext_sig;
    logic [7:0] count_value_o;
    int mismatches = 0, checked = 0;
    thl_row_s rows [21];
    always #20 clk_i = ~clk_i;
    thl_src thl_src_inst (.clk_i, .rst_i, .tick_i(tick_r), .lvl_i(lvl_r), .timer_clk_o(timer_clk),
        .ext_reset_signal_o(ext_sig));
    thl_timer thl_timer_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .timer_clk_i(timer_clk), .ext_reset_signal_i(ext_sig), .count_value_o, .run_o);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic wrap_up();
        $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request is held until ack is sampled high; a wait that runs out counts as a mismatch.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, dat};
        // Ack is looked at on the falling edge, where it has settled, never in the step that launches it.
        i = 0;
        @(negedge clk_i);
        while (wb_ack_o !== 1'b1 && i < 20)
        begin
            @(negedge clk_i);
            i++;
        end
        chk({31'h0, wb_ack_o}, 32'h1);
        rd = wb_dat_o;
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 8'h00);
        chk(rd, exp);
    endtask
    task automatic ticks(input logic [3:0] n);
        repeat (n)
        begin
            tick_r <= 1'b1;
            @(posedge clk_i);
            tick_r <= 1'b0;
            repeat (8) @(posedge clk_i);
        end
    endtask
    // Synchroniser latency must pass before a tick, or the edge lands one tick late.
    task automatic lvl(input logic v);
        lvl_r <= v;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic go(input logic [4:0] m);
        wb(1'b1, THL_ADR_CTRL, 8'h00);
        wb(1'b1, THL_ADR_COUNT, 8'h00);
        wb(1'b1, THL_ADR_CTRL, {3'b100, m});
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        wrap_up();
    end
    initial
    begin
        rows[0] = '{THL_M_FREE, 1'b0, 1'b0, 4'h5, 8'h01, 1'b1};
        rows[1] = '{THL_M_LIM_ANY, 1'b1, 1'b1, 4'h1, 8'h00, 1'b1};
        rows[2] = '{THL_M_LIM_RISE, 1'b0, 1'b1, 4'h1, 8'h00, 1'b1};
        rows[3] = '{THL_M_LIM_FALL, 1'b0, 1'b1, 4'h1, 8'h03, 1'b1};
        rows[4] = '{THL_M_LVL_LOW, 1'b1, 1'b1, 4'h4, 8'h00, 1'b1};
        rows[5] = '{THL_M_LVL_HIGH, 1'b0, 1'b1, 4'h4, 8'h00, 1'b1};
        rows[6] = '{THL_M_OS_SW, 1'b0, 1'b0, 4'h4, 8'h00, 1'b0};
        rows[7] = '{THL_M_OS_RISE, 1'b0, 1'b1, 4'h3, 8'h02, 1'b1};
        rows[8] = '{THL_M_OS_FALL, 1'b1, 1'b1, 4'h3, 8'h02, 1'b1};
        rows[9] = '{THL_M_OS_ANY, 1'b0, 1'b1, 4'h8, 8'h00, 1'b0};
        rows[10] = '{THL_M_OSL_RISE, 1'b0, 1'b1, 4'h8, 8'h00, 1'b0};
        rows[11] = '{THL_M_OSL_FALL, 1'b1, 1'b1, 4'h3, 8'h02, 1'b1};
        rows[12] = '{THL_M_LRE_LOW, 1'b0, 1'b1, 4'h3, 8'h02, 1'b1};
        rows[13] = '{THL_M_LRE_HIGH, 1'b1, 1'b1, 4'h8, 8'h00, 1'b0};
        rows[14] = '{THL_M_LRE_LOW, 1'b0, 1'b0, 4'h3, 8'h00, 1'b1};
        rows[15] = '{THL_M_MONO_RISE, 1'b0, 1'b1, 4'h3, 8'h02, 1'b1};
        rows[16] = '{THL_M_MONO_FALL, 1'b1, 1'b1, 4'h3, 8'h02, 1'b1};
        rows[17] = '{THL_M_MONO_ANY, 1'b0, 1'b1, 4'h8, 8'h00, 1'b1};
        rows[18] = '{THL_M_LOS_LOW, 1'b0, 1'b1, 4'h3, 8'h03, 1'b1};
        rows[19] = '{THL_M_LOS_HIGH, 1'b1, 1'b1, 4'h8, 8'h00, 1'b0};
        rows[20] = '{5'h18, 1'b0, 1'b0, 4'h3, 8'h00, 1'b1};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(THL_ADR_COUNT, 32'h00);
        rdc(THL_ADR_PERIOD, 32'hFF);
        rdc(THL_ADR_CTRL, 32'h00);
        rdc(8'h0C, 32'h00);
        wb(1'b1, THL_ADR_PERIOD, 8'h05);
        foreach (rows[k])
        begin
            wb(1'b1, THL_ADR_CTRL, 8'h00);
            lvl(rows[k].lvl);
            go(rows[k].mode);
            ticks(4'h2);
            lvl(rows[k].tog ^ rows[k].lvl);
            ticks(rows[k].n);
            rdc(THL_ADR_COUNT, {24'h0, rows[k].cnt});
            rdc(THL_ADR_CTRL, {24'h0, rows[k].run, 2'b00, rows[k].mode});
            $display("Test row %0d done", k);
        end
        go(THL_M_OS_SW);
        ticks(4'h2);
        wb(1'b1, THL_ADR_CTRL, {3'b000, THL_M_OS_SW});
        ticks(4'h2);
        rdc(THL_ADR_COUNT, 32'h02);
        wb(1'b1, THL_ADR_CTRL, {3'b100, THL_M_OS_SW});
        ticks(4'h4);
        rdc(THL_ADR_CTRL, {27'h0, THL_M_OS_SW});
        chk({31'h0, run_o}, 32'h0);
        chk({24'h0, count_value_o}, 32'h0);
        wb_sel_i <= 4'hE;
        wb(1'b1, THL_ADR_PERIOD, 8'h33);
        wb_sel_i <= 4'hF;
        rdc(THL_ADR_PERIOD, 32'h05);
        $display("Test pause done");
        lvl(1'b0);
        go(THL_M_OSL_RISE);
        lvl(1'b1);
        ticks(4'h3);
        lvl(1'b0);
        ticks(4'h1);
        lvl(1'b1);
        ticks(4'h1);
        rdc(THL_ADR_COUNT, 32'h00);
        ticks(4'h2);
        rdc(THL_ADR_COUNT, 32'h01);
        $display("Test limit restart done");
        go(THL_M_FREE);
        ticks(4'h2);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(THL_ADR_COUNT, 32'h00);
        rdc(THL_ADR_PERIOD, 32'hFF);
        rdc(THL_ADR_CTRL, 32'h00);
        $display("Test second reset done");
        wrap_up();
    end
endmodule // testbench
